/* File: hw/sfdc_pkg.sv */
// package for the serial fed display control block: modes, states, timing
// assumes a 100 MHz system clock and a single asynchronous active-low reset
`default_nettype none
package sfdc_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MENU_HOLD_MS = 2000;
  localparam int unsigned MENU_HOLD_CYC = (CLK_HZ / 1000) * MENU_HOLD_MS;
  localparam int unsigned SPLASH_MS = 1000;
  localparam int unsigned SPLASH_CYC = (CLK_HZ / 1000) * SPLASH_MS;
  localparam int unsigned TICK_MS_CYC = CLK_HZ / 1000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned DIGITS = 6;
  localparam logic [15:0] TIMEOUT_MS_RST = 16'h03E8;

  // ----------------------------------------------------------------------
  // displayable ranges
  // ----------------------------------------------------------------------
  localparam logic signed [31:0] MIN4 = -32'sd999;
  localparam logic signed [31:0] MAX4 = 32'sd9999;
  localparam logic signed [31:0] MIN6 = -32'sd99999;
  localparam logic signed [31:0] MAX6 = 32'sd999999;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic {SFDC_FOLLOWER, SFDC_INITIATOR} sfdc_role_e;
  typedef enum logic [2:0] {
    SFDC_SHOW_ID, SFDC_SHOW_DASH, SFDC_SHOW_VALUE, SFDC_SHOW_OVER,
    SFDC_SHOW_UNDER, SFDC_SHOW_MENU, SFDC_SHOW_CUSTOM
  } sfdc_show_e;
  typedef enum logic [1:0] {
    SFDC_MENU_NONE, SFDC_MENU_MAIN, SFDC_MENU_FOLLOWER
  } sfdc_menu_e;

  // value update arriving from the frame handler
  typedef struct packed {
    logic valid;
    logic signed [31:0] value;
    logic [2:0] point;
  } sfdc_update_s;

  // configuration word, held live and in the edit shadow
  typedef struct packed {
    sfdc_role_e role;
    logic six_digit;
    logic [15:0] timeout_ms;
  } sfdc_cfg_s;

  localparam sfdc_cfg_s CFG_RST = '{SFDC_FOLLOWER, 1'b0, TIMEOUT_MS_RST};

  // segment pattern override for one digit
  typedef struct packed {
    logic valid;
    logic [2:0] position;
    logic [7:0] segments;
  } sfdc_custom_s;
endpackage : sfdc_pkg
`default_nettype wire

/* File: hw/sfdc_hold_timer.sv */
// key hold detector: pulses once when a synchronised key has been held
// assumes the key input is already synchronised to i_clock
`default_nettype none
module sfdc_hold_timer #(
  parameter int unsigned HOLD_CYC = sfdc_pkg::MENU_HOLD_CYC
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_key,
  output logic o_held
);
  import sfdc_pkg::*;
  logic [31:0] count_reg;
  logic fired_reg;

  // ----------------------------------------------------------------------
  // counting; any release restarts, so the hold must be continuous
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= 32'h0;
      fired_reg <= 1'b0;
      o_held <= 1'b0;
    end else begin
      o_held <= 1'b0;
      if (!i_key) begin
        count_reg <= 32'h0;
        fired_reg <= 1'b0;
      end else if (!fired_reg) begin
        if (count_reg == HOLD_CYC - 1) begin
          o_held <= 1'b1;
          fired_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + 32'h1;
        end
      end
    end
  end
endmodule : sfdc_hold_timer
`default_nettype wire

/* File: hw/sfdc_stale_timer.sv */
// stale-data timer: counts milliseconds since the last valid update
// assumes a one-cycle millisecond tick enable from the parent
`default_nettype none
module sfdc_stale_timer (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_ms_tick,
  input wire logic i_restart,
  input wire logic [15:0] i_limit_ms,
  output logic o_stale
);
  import sfdc_pkg::*;
  logic [15:0] ms_reg;

  // ----------------------------------------------------------------------
  // restart wins over the tick so a fresh update is never stale
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ms_reg <= 16'h0;
      o_stale <= 1'b0;
    end else if (i_restart) begin
      ms_reg <= 16'h0;
      o_stale <= 1'b0;
    end else if (i_ms_tick && !o_stale) begin
      if (ms_reg + 16'h1 >= i_limit_ms) begin
        o_stale <= 1'b1;
      end
      ms_reg <= ms_reg + 16'h1;
    end
  end
endmodule : sfdc_stale_timer
`default_nettype wire

/* File: hw/sfdc_display_ctrl.sv */
// top of the serial fed display control: screen selection, range check,
// stale blinking, menu entry and parameter commit
// assumes frame handling lives outside and hands over decoded updates
//
// Contract
// - after reset show the identity screen, then enter value display
// - show dashes until the first value update arrives
// - a stored role setting selects initiator or follower behaviour
// - initiator role takes value and decimal point from polled reply
// - values above the upper limit show the over-range message
// - values below the lower limit show the under-range message
// - four digits: -999 to 9999 displayable
// - six digits: -99999 to 999999 displayable
// - follower: no rewrite within the timeout makes the value blink
// - blinking stops on the next valid write
// - follower role allows custom segment patterns at chosen digits
// - follower settings menu offered only in follower role
// - main menu only after cancel key held two seconds continuously
// - cancel discards pending edit, confirm commits it
// - every parameter is also writable over the serial link
// - configuration changes never stop display or communication
// - initiator: no reply within timeout blinks until a good read
`default_nettype none
module sfdc_display_ctrl #(
  // long counts; a bench may shorten them to keep runs small
  parameter int unsigned SPLASH_CYCLES = sfdc_pkg::SPLASH_CYC,
  parameter int unsigned HOLD_CYCLES = sfdc_pkg::MENU_HOLD_CYC,
  parameter int unsigned MS_CYCLES = sfdc_pkg::TICK_MS_CYC
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire sfdc_pkg::sfdc_update_s i_write_update,
  input wire sfdc_pkg::sfdc_update_s i_read_update,
  input wire logic i_poll_sent,
  input wire sfdc_pkg::sfdc_custom_s i_custom,
  input wire logic i_cfg_write,
  input wire sfdc_pkg::sfdc_cfg_s i_cfg_data,
  input wire logic i_cancel_menu_key,
  input wire logic i_confirm_key,
  input wire logic i_edit_start,
  input wire sfdc_pkg::sfdc_cfg_s i_edit_data,
  output sfdc_pkg::sfdc_show_e o_show,
  output logic signed [31:0] o_value,
  output logic [2:0] o_point,
  output logic o_blank,
  output logic [7:0] o_custom_seg,
  output logic [2:0] o_custom_pos,
  output logic o_custom_en,
  output sfdc_pkg::sfdc_menu_e o_menu,
  output logic o_editing,
  output sfdc_pkg::sfdc_cfg_s o_cfg
);
  import sfdc_pkg::*;

  // ----------------------------------------------------------------------
  // key synchronisers: keys are pins from outside the clock domain
  // ----------------------------------------------------------------------
  logic [1:0] cancel_sync_reg;
  logic [1:0] confirm_sync_reg;
  logic cancel_prev_reg;
  logic confirm_prev_reg;
  logic cancel_press;
  logic confirm_press;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cancel_sync_reg <= 2'h0;
      confirm_sync_reg <= 2'h0;
      cancel_prev_reg <= 1'b0;
      confirm_prev_reg <= 1'b0;
    end else begin
      cancel_sync_reg <= {cancel_sync_reg[0], i_cancel_menu_key};
      confirm_sync_reg <= {confirm_sync_reg[0], i_confirm_key};
      cancel_prev_reg <= cancel_sync_reg[1];
      confirm_prev_reg <= confirm_sync_reg[1];
    end
  end

  // edge detection reads only the second stage
  assign cancel_press = cancel_sync_reg[1] && !cancel_prev_reg;
  assign confirm_press = confirm_sync_reg[1] && !confirm_prev_reg;

  // ----------------------------------------------------------------------
  // millisecond enable and blink phase
  // ----------------------------------------------------------------------
  logic [31:0] ms_div_reg;
  logic ms_tick_reg;
  logic [15:0] blink_ms_reg;
  logic blink_phase_reg;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ms_div_reg <= 32'h0;
      ms_tick_reg <= 1'b0;
    end else if (ms_div_reg == MS_CYCLES - 1) begin
      ms_div_reg <= 32'h0;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_div_reg <= ms_div_reg + 32'h1;
      ms_tick_reg <= 1'b0;
    end
  end

  // blink phase toggles every half period
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      blink_ms_reg <= 16'h0;
      blink_phase_reg <= 1'b0;
    end else if (ms_tick_reg) begin
      if (blink_ms_reg == 16'(BLINK_HALF_MS - 1)) begin
        blink_ms_reg <= 16'h0;
        blink_phase_reg <= !blink_phase_reg;
      end else begin
        blink_ms_reg <= blink_ms_reg + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration: live copy, edit shadow, remote writes
  // ----------------------------------------------------------------------
  sfdc_cfg_s cfg_reg;
  sfdc_cfg_s shadow_reg;
  logic editing_reg;
  sfdc_menu_e menu_reg;
  logic menu_hold;

  // remote writes land directly; display keeps running meanwhile
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg <= CFG_RST;
    end else if (i_cfg_write) begin
      cfg_reg <= i_cfg_data;
    end else if (editing_reg && confirm_press) begin
      cfg_reg <= shadow_reg;
    end
  end

  // shadow holds uncommitted edits; cancel simply drops it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      shadow_reg <= CFG_RST;
      editing_reg <= 1'b0;
    end else if (editing_reg && (cancel_press || confirm_press)) begin
      editing_reg <= 1'b0;
    end else if (i_edit_start && menu_reg != SFDC_MENU_NONE) begin
      shadow_reg <= i_edit_data;
      editing_reg <= 1'b1;
    end
  end

  sfdc_hold_timer #(
    .HOLD_CYC(HOLD_CYCLES)
  ) u_hold (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_key(cancel_sync_reg[1]),
    .o_held(menu_hold)
  );

  // menu level; follower submenu only while follower role stands
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      menu_reg <= SFDC_MENU_NONE;
    end else begin
      case (menu_reg)
        SFDC_MENU_NONE: begin
          if (menu_hold) begin
            menu_reg <= SFDC_MENU_MAIN;
          end
        end
        SFDC_MENU_MAIN: begin
          if (cancel_press && !editing_reg) begin
            menu_reg <= SFDC_MENU_NONE;
          end else if (confirm_press && !editing_reg &&
                       cfg_reg.role == SFDC_FOLLOWER) begin
            menu_reg <= SFDC_MENU_FOLLOWER;
          end
        end
        SFDC_MENU_FOLLOWER: begin
          if (cfg_reg.role != SFDC_FOLLOWER) begin
            menu_reg <= SFDC_MENU_MAIN;
          end else if (cancel_press && !editing_reg) begin
            menu_reg <= SFDC_MENU_MAIN;
          end
        end
        default: begin
          menu_reg <= SFDC_MENU_NONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // value capture: role selects the source
  // ----------------------------------------------------------------------
  sfdc_update_s upd;
  logic have_value_reg;
  logic signed [31:0] value_reg;
  logic [2:0] point_reg;
  logic stale;
  logic stale_restart;

  always_comb begin
    if (cfg_reg.role == SFDC_INITIATOR) begin
      upd = i_read_update;
    end else begin
      upd = i_write_update;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      have_value_reg <= 1'b0;
      value_reg <= 32'sh0;
      point_reg <= 3'h0;
    end else if (upd.valid) begin
      have_value_reg <= 1'b1;
      value_reg <= upd.value;
      point_reg <= upd.point;
    end
  end

  // initiator also restarts on each poll sent while not stale so the wait runs from the request
  assign stale_restart = upd.valid ||
    (cfg_reg.role == SFDC_INITIATOR && i_poll_sent && !stale);

  sfdc_stale_timer u_stale (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_ms_tick(ms_tick_reg),
    .i_restart(stale_restart),
    .i_limit_ms(cfg_reg.timeout_ms),
    .o_stale(stale)
  );

  // ----------------------------------------------------------------------
  // power-up identity screen
  // ----------------------------------------------------------------------
  logic [31:0] splash_reg;
  logic splash_done_reg;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      splash_reg <= 32'h0;
      splash_done_reg <= 1'b0;
    end else if (!splash_done_reg) begin
      if (splash_reg == SPLASH_CYCLES - 1) begin
        splash_done_reg <= 1'b1;
      end else begin
        splash_reg <= splash_reg + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // range check and screen choice
  // ----------------------------------------------------------------------
  logic signed [31:0] lo_lim;
  logic signed [31:0] hi_lim;
  sfdc_show_e show_next;

  assign lo_lim = cfg_reg.six_digit ? MIN6 : MIN4;
  assign hi_lim = cfg_reg.six_digit ? MAX6 : MAX4;

  always_comb begin
    if (!splash_done_reg) begin
      show_next = SFDC_SHOW_ID;
    end else if (menu_reg != SFDC_MENU_NONE) begin
      show_next = SFDC_SHOW_MENU;
    end else if (!have_value_reg) begin
      show_next = SFDC_SHOW_DASH;
    end else if (value_reg > hi_lim) begin
      show_next = SFDC_SHOW_OVER;
    end else if (value_reg < lo_lim) begin
      show_next = SFDC_SHOW_UNDER;
    end else begin
      show_next = SFDC_SHOW_VALUE;
    end
  end

  // outputs registered; blanking is the off half of the blink
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_show <= SFDC_SHOW_ID;
      o_value <= 32'sh0;
      o_point <= 3'h0;
      o_blank <= 1'b0;
      o_menu <= SFDC_MENU_NONE;
      o_editing <= 1'b0;
      o_cfg <= CFG_RST;
    end else begin
      o_show <= show_next;
      o_value <= value_reg;
      o_point <= point_reg;
      o_blank <= stale && have_value_reg && splash_done_reg &&
        menu_reg == SFDC_MENU_NONE && blink_phase_reg;
      o_menu <= menu_reg;
      o_editing <= editing_reg;
      o_cfg <= cfg_reg;
    end
  end

  // custom segment patterns, follower role only
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_custom_seg <= 8'h00;
      o_custom_pos <= 3'h0;
      o_custom_en <= 1'b0;
    end else if (cfg_reg.role != SFDC_FOLLOWER) begin
      o_custom_en <= 1'b0;
    end else if (i_custom.valid &&
                 i_custom.position < 3'(DIGITS)) begin
      o_custom_seg <= i_custom.segments;
      o_custom_pos <= i_custom.position;
      o_custom_en <= 1'b1;
    end
  end
endmodule : sfdc_display_ctrl
`default_nettype wire

/* File: testbench/sfdc_display_ctrl_checker.sv */
// port-level checker for the serial fed display control top
// assumes one clock domain and the timing constants of sfdc_pkg
`default_nettype none
module sfdc_display_ctrl_checker #(
  parameter int unsigned HOLD_CYC = sfdc_pkg::MENU_HOLD_CYC
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire sfdc_pkg::sfdc_update_s i_write_update,
  input wire sfdc_pkg::sfdc_update_s i_read_update,
  input wire sfdc_pkg::sfdc_custom_s i_custom,
  input wire logic i_cfg_write,
  input wire sfdc_pkg::sfdc_cfg_s i_cfg_data,
  input wire logic i_cancel_menu_key,
  input wire sfdc_pkg::sfdc_show_e o_show,
  input wire logic signed [31:0] o_value,
  input wire logic [2:0] o_point,
  input wire logic o_blank,
  input wire logic o_custom_en,
  input wire sfdc_pkg::sfdc_menu_e o_menu,
  input wire sfdc_pkg::sfdc_cfg_s o_cfg
);
  import sfdc_pkg::*;
  // ----------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------
  logic take_w;
  logic take_r;
  logic seen_reg;
  logic [31:0] hold_reg;
  assign take_w = i_write_update.valid && o_cfg.role == SFDC_FOLLOWER;
  assign take_r = i_read_update.valid && o_cfg.role == SFDC_INITIATOR;
  // remembers that some value update was accepted since reset
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      seen_reg <= 1'b0;
    end else if (take_w || take_r) begin
      seen_reg <= 1'b1;
    end
  end
  // raw key hold length; saturates so a long press cannot wrap
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn || !i_cancel_menu_key) begin
      hold_reg <= 32'h0;
    end else if (hold_reg != 32'hFFFFFFFF) begin
      hold_reg <= hold_reg + 32'h1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_SPLASH: assert property (
    $rose(i_resetn) |-> (o_show == SFDC_SHOW_ID) [*8])
    else $error("identity screen left too early");
  AST_DASH: assert property (
    !seen_reg |-> o_show inside {SFDC_SHOW_ID, SFDC_SHOW_DASH, SFDC_SHOW_MENU})
    else $error("value shown before any update");
  AST_WRITE: assert property (
    take_w |-> ##2 o_value == $past(i_write_update.value, 2))
    else $error("follower write not shown two cycles later");
  AST_REFUSE: assert property (
    o_cfg.role == SFDC_INITIATOR && i_write_update.valid
      && !i_read_update.valid |-> ##2 $stable(o_value))
    else $error("write accepted in initiator role");
  AST_READ: assert property (
    take_r |-> ##2 o_value == $past(i_read_update.value, 2)
      && o_point == $past(i_read_update.point, 2))
    else $error("poll reply value or point not taken");
  AST_OVER: assert property (
    o_show == SFDC_SHOW_OVER && $stable(o_cfg.six_digit)
      |-> o_value > (o_cfg.six_digit ? MAX6 : MAX4))
    else $error("over-range message for a displayable value");
  AST_UNDER: assert property (
    o_show == SFDC_SHOW_UNDER && $stable(o_cfg.six_digit)
      |-> o_value < (o_cfg.six_digit ? MIN6 : MIN4))
    else $error("under-range message for a displayable value");
  AST_RANGE: assert property (
    o_show == SFDC_SHOW_VALUE && $stable(o_cfg.six_digit)
      |-> o_value <= (o_cfg.six_digit ? MAX6 : MAX4)
      && o_value >= (o_cfg.six_digit ? MIN6 : MIN4))
    else $error("value shown outside the displayable range");
  AST_UNBLINK: assert property (
    take_w || take_r |-> ##[1:3] !o_blank)
    else $error("blinking kept after a valid update");
  AST_CUSTOM: assert property (
    i_custom.valid && i_custom.position < 3'h6
      && o_cfg.role == SFDC_FOLLOWER |-> ##[1:2] o_custom_en)
    else $error("custom pattern not taken");
  AST_NOCUSTOM: assert property (
    o_cfg.role == SFDC_INITIATOR && $past(o_cfg.role) == SFDC_INITIATOR
      |-> !o_custom_en)
    else $error("custom pattern kept in initiator role");
  AST_FOLMENU: assert property (
    o_menu == SFDC_MENU_MAIN ##1 o_menu == SFDC_MENU_FOLLOWER
      |-> $past(o_cfg.role) == SFDC_FOLLOWER)
    else $error("follower menu offered in initiator role");
  AST_HOLD: assert property (
    o_menu == SFDC_MENU_NONE ##1 o_menu != SFDC_MENU_NONE
      |-> $past(hold_reg, 4) >= HOLD_CYC)
    else $error("menu entered without a full key hold");
  AST_CFG: assert property (
    i_cfg_write |-> ##2 o_cfg == $past(i_cfg_data, 2))
    else $error("remote configuration write not applied");
  // main scenarios reached
  COV_WRITE: cover property (take_w ##1 take_w);
  COV_READ: cover property (take_r);
  COV_CUSTOM: cover property ($rose(o_custom_en));
  COV_CFG: cover property (i_cfg_write && o_cfg.role == SFDC_INITIATOR);
endmodule : sfdc_display_ctrl_checker

bind sfdc_display_ctrl sfdc_display_ctrl_checker #(
  .HOLD_CYC(HOLD_CYCLES)
) i_checker (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_write_update(i_write_update),
  .i_read_update(i_read_update), .i_custom(i_custom),
  .i_cfg_write(i_cfg_write), .i_cfg_data(i_cfg_data),
  .i_cancel_menu_key(i_cancel_menu_key), .o_show(o_show),
  .o_value(o_value), .o_point(o_point), .o_blank(o_blank),
  .o_custom_en(o_custom_en), .o_menu(o_menu), .o_cfg(o_cfg)
);
`default_nettype wire

/* File: testbench/sfdc_link_model.sv */
// far side of the link: remote controller writes and polled replies
// assumes the bench calls its tasks at the falling clock edge
`default_nettype none
module sfdc_link_model (
  input wire logic i_clock,
  output sfdc_pkg::sfdc_update_s o_write_update,
  output sfdc_pkg::sfdc_update_s o_read_update,
  output logic o_poll_sent,
  output logic o_cfg_write,
  output sfdc_pkg::sfdc_cfg_s o_cfg_data
);
  import sfdc_pkg::*;
  // quiet link at time zero
  initial begin
    o_write_update = '0;
    o_read_update = '0;
    o_poll_sent = 1'b0;
    o_cfg_write = 1'b0;
    o_cfg_data = CFG_RST;
  end
  // one update per cycle; the caller releases with idle
  task automatic put(input logic rd, input logic signed [31:0] v,
      input logic [2:0] p);
    if (rd) begin
      o_read_update = '{1'b1, v, p};
    end else begin
      o_write_update = '{1'b1, v, p};
    end
    @(negedge i_clock);
  endtask : put
  // released data is inverted so a stale copy is never mistaken for news
  task automatic idle();
    o_write_update = '{1'b0, ~o_write_update.value, ~o_write_update.point};
    o_read_update = '{1'b0, ~o_read_update.value, ~o_read_update.point};
    o_poll_sent = 1'b0;
    o_cfg_write = 1'b0;
    o_cfg_data = sfdc_cfg_s'(~o_cfg_data);
  endtask : idle
  // request, then a reply after a chosen number of idle cycles
  task automatic poll(input logic signed [31:0] v, input logic [2:0] p,
      input int gap);
    o_poll_sent = 1'b1;
    @(negedge i_clock);
    idle();
    repeat (gap) @(negedge i_clock);
    put(1'b1, v, p);
    idle();
  endtask : poll
  // remote configuration write
  task automatic cfg(input sfdc_cfg_s c);
    o_cfg_write = 1'b1;
    o_cfg_data = c;
    @(negedge i_clock);
    idle();
    // live copy shows one cycle after the write lands
    @(negedge i_clock);
  endtask : cfg
endmodule : sfdc_link_model
`default_nettype wire

/* File: testbench/test_serial_fed_display_control.sv */
// self-checking bench for the serial fed display control top
// assumes shortened splash, key hold and millisecond counts in the top
`default_nettype none
module test_serial_fed_display_control;
  timeunit 1ns;
  timeprecision 100ps;
  import sfdc_pkg::*;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  sfdc_update_s wr_upd, rd_upd;
  sfdc_custom_s custom = '0;
  sfdc_cfg_s cfg_data, edit_data = CFG_RST, cfg;
  logic poll_sent, cfg_write, cancel = 1'b0, confirm = 1'b0, edit = 1'b0;
  sfdc_show_e show;
  sfdc_menu_e menu;
  logic signed [31:0] value;
  logic [2:0] point, cpos;
  logic [7:0] cseg;
  logic blank, cen, editing;
  int num_errors = 0, n_compared = 0, cycles = 0;
  sfdc_link_model m (.i_clock(i_clock), .o_write_update(wr_upd),
    .o_read_update(rd_upd), .o_poll_sent(poll_sent),
    .o_cfg_write(cfg_write), .o_cfg_data(cfg_data));
  sfdc_display_ctrl #(.SPLASH_CYCLES(20), .HOLD_CYCLES(40),
    .MS_CYCLES(4)) i_dut (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_write_update(wr_upd), .i_read_update(rd_upd),
    .i_poll_sent(poll_sent), .i_custom(custom), .i_cfg_write(cfg_write),
    .i_cfg_data(cfg_data), .i_cancel_menu_key(cancel),
    .i_confirm_key(confirm), .i_edit_start(edit), .i_edit_data(edit_data),
    .o_show(show), .o_value(value), .o_point(point), .o_blank(blank),
    .o_custom_seg(cseg), .o_custom_pos(cpos), .o_custom_en(cen),
    .o_menu(menu), .o_editing(editing), .o_cfg(cfg));
  always #5 i_clock = ~i_clock;
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic signed [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // two blink waits of at most 4100 cycles dominate the run
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // custom pattern pulse; lines scrambled once released
  task automatic put_custom(input logic [2:0] p, input logic [7:0] s);
    custom = '{1'b1, p, s};
    @(negedge i_clock);
    custom = '{1'b0, ~p, ~s};
    @(negedge i_clock);
  endtask : put_custom
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    check(32'(show), 32'(SFDC_SHOW_ID));
    check(32'(cfg), 32'(CFG_RST));
    check(32'(blank), 32'h0);
    repeat (200) @(negedge i_clock);
    check(32'(show), 32'(SFDC_SHOW_DASH));
  endtask : t_reset
  task automatic t_writes();
    logic signed [31:0] tbl [4];
    sfdc_show_e shw [4];
    tbl = '{MIN4, MIN4 - 32'sh1, MAX6, MAX6 + 32'sh1};
    shw = '{SFDC_SHOW_VALUE, SFDC_SHOW_UNDER, SFDC_SHOW_OVER, SFDC_SHOW_OVER};
    for (int i = 0; i < 5; i++) begin
      if (i < 4) begin
        m.put(1'b0, tbl[i], 3'(i));
      end else begin
        m.idle();
        @(negedge i_clock);
      end
      if (i > 0) begin
        check(value, tbl[i-1]);
        check(32'(point), 32'(i - 1));
        check(32'(show), 32'(shw[i-1]));
        check(32'(blank), 32'h0);
      end
    end
  endtask : t_writes
  task automatic t_roles();
    m.cfg('{SFDC_INITIATOR, 1'b1, 16'h0005});
    check(32'(cfg), 32'({SFDC_INITIATOR, 1'b1, 16'h0005}));
    m.put(1'b0, MAX4, 3'h0);
    m.idle();
    @(negedge i_clock);
    check(value, MAX6 + 32'sh1);
    m.poll(MIN6, 3'h4, 3);
    @(negedge i_clock);
    check(value, MIN6);
    check(32'(point), 32'h4);
    m.cfg(CFG_RST);
    m.put(1'b0, MAX4, 3'h5);
    m.idle();
    @(negedge i_clock);
    check(value, MAX4);
  endtask : t_roles
  task automatic t_custom();
    put_custom(3'h2, 8'hA5);
    check(32'(cen), 32'h1);
    check(32'(cpos), 32'h2);
    check(32'(cseg), 32'hA5);
    put_custom(3'h6, 8'h3C);
    check(32'(cseg), 32'hA5);
    m.cfg('{SFDC_INITIATOR, 1'b0, 16'h0005});
    @(negedge i_clock);
    check(32'(cen), 32'h0);
  endtask : t_custom
  // silent link: stale after 5 ms, blank within one blink period
  task automatic t_stale(input logic rd);
    m.cfg('{sfdc_role_e'(rd), 1'b0, 16'h0005});
    m.put(rd, 32'sh7, 3'h1);
    m.idle();
    repeat (4100) if (!blank) @(negedge i_clock);
    check(32'(blank), 32'h1);
    m.put(rd, 32'sh8, 3'h1);
    m.idle();
    @(negedge i_clock);
    check(32'(blank), 32'h0);
  endtask : t_stale
  // one key held n cycles, then time for the synchroniser to settle
  task automatic key(input logic sel, input int n);
    confirm = sel;
    cancel = !sel;
    repeat (n) @(negedge i_clock);
    confirm = 1'b0;
    cancel = 1'b0;
    repeat (4) @(negedge i_clock);
  endtask : key
  task automatic t_keys();
    key(1'b0, 30);
    check(32'(menu), 32'(SFDC_MENU_NONE));
    key(1'b0, 50);
    check(32'(menu), 32'(SFDC_MENU_MAIN));
    key(1'b1, 2);
    check(32'(menu), 32'(SFDC_MENU_FOLLOWER));
    // first edit is cancelled, second confirmed
    for (int i = 0; i < 2; i++) begin
      edit = 1'b1;
      edit_data = '{SFDC_FOLLOWER, 1'b1, 16'h0009};
      @(negedge i_clock);
      edit = 1'b0;
      edit_data = sfdc_cfg_s'(~edit_data);
      @(negedge i_clock);
      check(32'(editing), 32'h1);
      key(i[0], 2);
      check(32'(editing), 32'h0);
      check(32'(cfg), i ? 32'h10009 : 32'h00005);
    end
  endtask : t_keys
  initial begin
    repeat (10) @(negedge i_clock);
    i_resetn = 1'b1;
    @(negedge i_clock);
    t_reset();
    t_writes();
    t_roles();
    t_custom();
    t_stale(1'b1);
    t_stale(1'b0);
    t_keys();
    stop_test();
  end
endmodule : test_serial_fed_display_control
`default_nettype wire
